// >>> rtl/fpu_cfg_params.svh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef FPU_CFG_PARAMS_SVH
`define FPU_CFG_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CONFIG      8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_MASK    8'h08

// ----------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------
`define CFG_RESET       32'hffe00420
`define CFG_WR_MASK     32'hffe0037f
`define CFG_MUL_HI      31
`define CFG_MUL_LO      26
`define CFG_ALU_HI      25
`define CFG_ALU_LO      21
`define CFG_REV_BIT     10
`define CFG_LOCAL_BIT   9
`define CFG_MEMSEL_BIT  8
`define CFG_RSVD7_BIT   7

// ----------------------------------------------------------------------
// Status and interrupt mask fields
// ----------------------------------------------------------------------
`define ST_WIDTH        12
`define ST_MUL_LO       0
`define ST_ALU_LO       6
`define ST_ED_BIT       11
`define ST_RESET        12'h000
`define IMASK_RESET     12'h000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define RESP_LATENCY    2

`endif

// >>> rtl/fpu_cfg_pkg.sv
// Types shared by the configuration register block.
package fpu_cfg_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic [1:0] {
    RESP_OKAY,
    RESP_EXOKAY,
    RESP_SLVERR,
    RESP_DECERR
  } axi_resp_t;

  typedef enum logic [1:0] {
    SEL_CONFIG,
    SEL_STATUS,
    SEL_MASK,
    SEL_NONE
  } reg_sel_t;

  typedef enum logic [1:0] {
    WR_COLLECT,
    WR_COMMIT,
    WR_RESPOND
  } wr_state_t;

endpackage : fpu_cfg_pkg

// >>> rtl/cfg_pin_mux.sv
// Pin steering for the local bus and memory space selects.
`timescale 1ns/10ps
module cfg_pin_mux (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Configuration
  input  wire logic        local_bus_cfg,
  input  wire logic        memory_select_cfg,
  input  wire logic        coproc_mode,
  // Local bus core side
  input  wire logic        local_output_enable,
  input  wire logic        cas_core,
  input  wire logic        we_core,
  input  wire logic        coproc_ready_out_core,
  input  wire logic        address_latch_out_core,
  input  wire logic        setmask_boundary,
  input  wire logic        lad_move_active,
  input  wire logic        lad_move_bit1,
  input  wire logic        lad_drive,
  input  wire logic [31:0] lad_core_data,
  // Memory core side
  input  wire logic        mem_access,
  input  wire logic        mem_is_data,
  // Local bus pins
  output logic             column_strobe_out,
  output logic             column_strobe_oe,
  output logic             write_strobe_out,
  output logic             write_strobe_oe,
  output logic             coproc_ready_out,
  output logic             cycle_boundary_out,
  output logic             address_latch_out,
  output logic [31:0]      local_addr_data_bus_o,
  output logic             local_addr_data_bus_oe,
  // Memory pins
  output logic             memory_chip_enable_n,
  output logic             space_select_pin
);

  logic        lad_mode;
  logic        float_pins;
  logic [8:0]  pins_d;
  logic [8:0]  pins_q;
  logic [31:0] lad_d;
  logic [31:0] lad_q;

  // ----------------------------------------------------------------------
  // Next pin values
  // ----------------------------------------------------------------------
  always_comb begin
    lad_mode   = local_bus_cfg & ~coproc_mode;
    float_pins = lad_mode & local_output_enable;
    pins_d[0]  = cas_core;
    pins_d[1]  = ~float_pins;
    pins_d[2]  = we_core;
    pins_d[3]  = ~float_pins;
    pins_d[4]  = coproc_ready_out_core;
    pins_d[5]  = address_latch_out_core;
    if (lad_mode) begin
      pins_d[6] = ~(lad_move_active & lad_move_bit1);
    end else begin
      pins_d[6] = setmask_boundary;
    end
    if (memory_select_cfg) begin
      pins_d[7] = ~(mem_access & ~mem_is_data);
      pins_d[8] = ~(mem_access & mem_is_data);
    end else begin
      pins_d[7] = ~mem_access;
      pins_d[8] = mem_is_data;
    end
    lad_d = lad_core_data;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pins_q <= 9'h1fb;
      lad_q  <= 32'h0000_0000;
    end else begin
      pins_q <= pins_d;
      lad_q  <= lad_d;
    end
  end

  assign column_strobe_out      = pins_q[0];
  assign column_strobe_oe       = pins_q[1];
  assign write_strobe_out       = pins_q[2];
  assign write_strobe_oe        = pins_q[3];
  assign coproc_ready_out       = pins_q[4];
  assign address_latch_out      = pins_q[5];
  assign cycle_boundary_out     = pins_q[6];
  assign memory_chip_enable_n   = pins_q[7];
  assign space_select_pin       = pins_q[8];
  assign local_addr_data_bus_o  = lad_q;
  assign local_addr_data_bus_oe = lad_drive & pins_q[1];

endmodule : cfg_pin_mux

// >>> rtl/fpu_config_register_upper.sv
// Configuration register, exception detect status and pin steering.
// Functional notes
// - 32-bit user register, resets to ffe00420
// - Bits 31..26 multiplier masks, reset enabled
// - Bits 25..21 ALU masks, reset enabled
// - Enabled exception sets detected flag, interrupt if unmasked
// - Bits 20..11 reserved, read zero
// - Bit 10 read-only hardwired revision
// - Local bit low: strobes ignore output enable
// - Local bit high: enable floats strobes, bus
// - Local bit high: move bit1 drives boundary
// - Local bit high: boundary high except during bit1 move
// - Local bit ignored in coprocessor mode
// - Memory bit high: separate code/data enables
// - Memory bit low: one enable both spaces
// - Memory bit low: select pin is address
`timescale 1ns/10ps
`include "fpu_cfg_params.svh"
module fpu_config_register_upper #(
  parameter logic REVISION_VALUE = 1'b0 // Arbitrary revision code.
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire fpu_cfg_pkg::word_t     s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output fpu_cfg_pkg::axi_resp_t      s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output fpu_cfg_pkg::word_t          s_axi_rdata,
  output fpu_cfg_pkg::axi_resp_t      s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Exception events from the arithmetic core
  input  wire logic [5:0]             mul_exception,
  input  wire logic [4:0]             alu_exception,
  // Operating mode
  input  wire logic                   coproc_mode,
  // Local bus core side
  input  wire logic                   local_output_enable,
  input  wire logic                   cas_core,
  input  wire logic                   we_core,
  input  wire logic                   coproc_ready_out_core,
  input  wire logic                   address_latch_out_core,
  input  wire logic                   setmask_boundary,
  input  wire logic                   lad_move_active,
  input  wire logic                   lad_move_bit1,
  input  wire logic                   lad_drive,
  input  wire logic [31:0]            lad_core_data,
  // Memory core side
  input  wire logic                   mem_access,
  input  wire logic                   mem_is_data,
  // Configuration outputs
  output logic [5:0]                  mul_mask,
  output logic [4:0]                  alu_mask,
  output logic [6:0]                  low_cfg,
  output logic                        exception_detected_flag,
  output logic                        irq,
  // Local bus pins
  output logic                        column_strobe_out,
  output logic                        column_strobe_oe,
  output logic                        write_strobe_out,
  output logic                        write_strobe_oe,
  output logic                        coproc_ready_out,
  output logic                        cycle_boundary_out,
  output logic                        address_latch_out,
  output logic [31:0]                 local_addr_data_bus_o,
  output logic                        local_addr_data_bus_oe,
  // Memory pins
  output logic                        memory_chip_enable_n,
  output logic                        space_select_pin
);
  import fpu_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic reg_sel_t decode(input logic [7:0] addr);
    case (addr)
      `OFS_CONFIG:   decode = SEL_CONFIG;
      `OFS_STATUS:   decode = SEL_STATUS;
      `OFS_IRQ_MASK: decode = SEL_MASK;
      default:       decode = SEL_NONE;
    endcase
  endfunction : decode

  function automatic word_t lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  word_t                 cfg_q;
  word_t                 cfg_d;
  logic [`ST_WIDTH-1:0]  status_q;
  logic [`ST_WIDTH-1:0]  status_d;
  logic [`ST_WIDTH-1:0]  imask_q;
  logic [`ST_WIDTH-1:0]  imask_d;
  logic [`ST_WIDTH-1:0]  events;
  logic [`ST_WIDTH-1:0]  w1c;
  word_t                 cfg_view;
  word_t                 wr_lanes;
  wr_state_t             wst_q;
  wr_state_t             wst_d;
  logic                  aw_got_q;
  logic                  aw_got_d;
  logic                  w_got_q;
  logic                  w_got_d;
  logic [7:0]            awaddr_q;
  logic [7:0]            awaddr_d;
  word_t                 wdata_q;
  word_t                 wdata_d;
  logic [3:0]            wstrb_q;
  logic [3:0]            wstrb_d;
  axi_resp_t             bresp_q;
  axi_resp_t             bresp_d;
  logic                  rvalid_q;
  logic                  rvalid_d;
  word_t                 rdata_q;
  word_t                 rdata_d;
  axi_resp_t             rresp_q;
  axi_resp_t             rresp_d;
  logic                  do_write;
  reg_sel_t              wsel;
  reg_sel_t              rsel;

  // ----------------------------------------------------------------------
  // Read view of the configuration register
  // ----------------------------------------------------------------------
  always_comb begin
    cfg_view                 = cfg_q & `CFG_WR_MASK;
    cfg_view[`CFG_REV_BIT]   = REVISION_VALUE;
  end

  // ----------------------------------------------------------------------
  // AXI write path
  // ----------------------------------------------------------------------
  assign s_axi_awready = (wst_q == WR_COLLECT) & ~aw_got_q;
  assign s_axi_wready  = (wst_q == WR_COLLECT) & ~w_got_q;
  assign s_axi_bvalid  = (wst_q == WR_RESPOND);
  assign s_axi_bresp   = bresp_q;

  always_comb begin
    wst_d    = wst_q;
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bresp_d  = bresp_q;
    do_write = 1'b0;
    wsel     = decode(awaddr_q);
    case (wst_q)
      WR_COLLECT: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_got_d = 1'b1;
          awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_got_d = 1'b1;
          wdata_d = s_axi_wdata;
          wstrb_d = s_axi_wstrb;
        end
        if (aw_got_d && w_got_d) begin
          wst_d = WR_COMMIT;
        end
      end
      WR_COMMIT: begin
        do_write = 1'b1;
        bresp_d  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        aw_got_d = 1'b0;
        w_got_d  = 1'b0;
        wst_d    = WR_RESPOND;
      end
      WR_RESPOND: begin
        if (s_axi_bready) begin
          wst_d = WR_COLLECT;
        end
      end
      default: begin
        wst_d = WR_COLLECT;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wst_q    <= WR_COLLECT;
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bresp_q  <= RESP_OKAY;
    end else begin
      wst_q    <= wst_d;
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      bresp_q  <= bresp_d;
    end
  end

  // ----------------------------------------------------------------------
  // Registers: configuration, status and interrupt mask
  // ----------------------------------------------------------------------
  always_comb begin
    wr_lanes = lane_mask(wstrb_q);
    cfg_d    = cfg_q;
    imask_d  = imask_q;
    w1c      = '0;
    if (do_write && wsel == SEL_CONFIG) begin
      cfg_d = (cfg_q & ~(wr_lanes & `CFG_WR_MASK))
            | (wdata_q & wr_lanes & `CFG_WR_MASK);
    end
    if (do_write && wsel == SEL_MASK) begin
      imask_d = (imask_q & ~wr_lanes[`ST_WIDTH-1:0])
              | (wdata_q[`ST_WIDTH-1:0] & wr_lanes[`ST_WIDTH-1:0]);
    end
    if (do_write && wsel == SEL_STATUS) begin
      w1c = wdata_q[`ST_WIDTH-1:0] & wr_lanes[`ST_WIDTH-1:0];
    end
    events[`ST_MUL_LO +: 6] = mul_exception
                            & cfg_q[`CFG_MUL_HI:`CFG_MUL_LO];
    events[`ST_ALU_LO +: 5] = alu_exception
                            & cfg_q[`CFG_ALU_HI:`CFG_ALU_LO];
    events[`ST_ED_BIT]      = |events[`ST_ED_BIT-1:0];
    status_d = (status_q & ~w1c) | events;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q    <= `CFG_RESET;
      status_q <= `ST_RESET;
      imask_q  <= `IMASK_RESET;
    end else begin
      cfg_q    <= cfg_d;
      status_q <= status_d;
      imask_q  <= imask_d;
    end
  end

  assign mul_mask                = cfg_q[`CFG_MUL_HI:`CFG_MUL_LO];
  assign alu_mask                = cfg_q[`CFG_ALU_HI:`CFG_ALU_LO];
  assign low_cfg                 = cfg_q[6:0];
  assign exception_detected_flag = status_q[`ST_ED_BIT];
  assign irq                     = |(status_q & imask_q);

  // ----------------------------------------------------------------------
  // AXI read path
  // ----------------------------------------------------------------------
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    rsel     = decode(s_axi_araddr);
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (rsel)
        SEL_CONFIG: rdata_d = cfg_view;
        SEL_STATUS: rdata_d = {20'h00000, status_q};
        SEL_MASK:   rdata_d = {20'h00000, imask_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pin steering
  // ----------------------------------------------------------------------
  cfg_pin_mux u_pin_mux (
    .mclk                   (mclk),
    .rst                    (rst),
    .local_bus_cfg          (cfg_q[`CFG_LOCAL_BIT]),
    .memory_select_cfg      (cfg_q[`CFG_MEMSEL_BIT]),
    .coproc_mode            (coproc_mode),
    .local_output_enable    (local_output_enable),
    .cas_core               (cas_core),
    .we_core                (we_core),
    .coproc_ready_out_core             (coproc_ready_out_core),
    .address_latch_out_core             (address_latch_out_core),
    .setmask_boundary       (setmask_boundary),
    .lad_move_active        (lad_move_active),
    .lad_move_bit1          (lad_move_bit1),
    .lad_drive              (lad_drive),
    .lad_core_data          (lad_core_data),
    .mem_access             (mem_access),
    .mem_is_data            (mem_is_data),
    .column_strobe_out      (column_strobe_out),
    .column_strobe_oe       (column_strobe_oe),
    .write_strobe_out       (write_strobe_out),
    .write_strobe_oe        (write_strobe_oe),
    .coproc_ready_out       (coproc_ready_out),
    .cycle_boundary_out     (cycle_boundary_out),
    .address_latch_out      (address_latch_out),
    .local_addr_data_bus_o  (local_addr_data_bus_o),
    .local_addr_data_bus_oe (local_addr_data_bus_oe),
    .memory_chip_enable_n   (memory_chip_enable_n),
    .space_select_pin       (space_select_pin)
  );

endmodule : fpu_config_register_upper

// >>> verif/fpu_cfg_asserts.sv
// Assertion checker for the configuration register block.
`timescale 1ns/10ps
module fpu_cfg_asserts
  import fpu_cfg_pkg::*;
#(
  parameter logic REVISION_VALUE = 1'b0
) (
  // Clock and reset
  input wire logic                   mclk, rst,
  // Register bus
  input wire logic                   s_axi_awvalid, s_axi_awready,
  input wire logic                   s_axi_wvalid, s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic [7:0]             s_axi_araddr,
  input wire logic                   s_axi_arvalid, s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire fpu_cfg_pkg::word_t     s_axi_rdata,
  input wire fpu_cfg_pkg::axi_resp_t s_axi_rresp,
  // Exceptions and masks
  input wire logic [5:0]             mul_exception, mul_mask,
  input wire logic [4:0]             alu_exception, alu_mask,
  input wire logic                   exception_detected_flag,
  // Pins
  input wire logic                   coproc_mode, local_output_enable,
  input wire logic                   column_strobe_oe, write_strobe_oe,
  input wire logic                   setmask_boundary, lad_move_active,
  input wire logic                   lad_move_bit1, cycle_boundary_out,
  input wire logic                   lad_drive, local_addr_data_bus_oe,
  input wire logic                   mem_access, mem_is_data,
  input wire logic                   memory_chip_enable_n
);
  logic [7:0] rd_addr_q;
  logic [7:0] rd_addr_d;

  always_comb begin
    rd_addr_d = rd_addr_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_d = s_axi_araddr;
    end
  end

  always_ff @(posedge mclk) begin
    rd_addr_q <= rst ? 8'h00 : rd_addr_d;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence wr_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence cfg_read_shown;
    s_axi_rvalid && rd_addr_q == 8'h00 && s_axi_rresp == RESP_OKAY;
  endsequence

  AST_WR_RESP: assert property (
    wr_both_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_RD_RESP: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RSVD_ZERO: assert property (
    cfg_read_shown |-> s_axi_rdata[20:11] == 10'h000 && !s_axi_rdata[7])
    else $error("reserved bits not zero");
  AST_REV_FIXED: assert property (
    cfg_read_shown |-> s_axi_rdata[10] == REVISION_VALUE)
    else $error("revision bit wrong");
  AST_DETECT: assert property (
    |(mul_exception & mul_mask) || |(alu_exception & alu_mask)
    |=> exception_detected_flag) else $error("detect flag not set");
  AST_OE_KEEP: assert property (
    !$past(rst) && ($past(coproc_mode) || !$past(local_output_enable))
    |-> column_strobe_oe && write_strobe_oe) else $error("strobe floated");
  AST_BOUNDARY: assert property (
    !$past(rst) && $past(setmask_boundary) &&
    !($past(lad_move_active) && $past(lad_move_bit1))
    |-> cycle_boundary_out) else $error("boundary low");
  AST_LAD_OE: assert property (
    !lad_drive |-> !local_addr_data_bus_oe) else $error("bus driven");
  AST_CE_IDLE: assert property (
    !$past(rst) && !$past(mem_access) |-> memory_chip_enable_n)
    else $error("chip enable without access");
  AST_CE_CODE: assert property (
    !$past(rst) && $past(mem_access) && !$past(mem_is_data)
    |-> !memory_chip_enable_n) else $error("code access not enabled");
endmodule : fpu_cfg_asserts

bind fpu_config_register_upper fpu_cfg_asserts #(
  .REVISION_VALUE(REVISION_VALUE)
) u_asserts (.*);

// >>> verif/ext_mem_model.sv
// External memory decode seen from the memory side.
`timescale 1ns/10ps
module ext_mem_model (
  // Pins
  input  wire logic memory_chip_enable_n,
  input  wire logic space_select_pin,
  // Board strap
  input  wire logic split_mode,
  // Decoded selects
  output logic      code_sel,
  output logic      data_sel
);
  always_comb begin
    if (split_mode) begin
      code_sel = !memory_chip_enable_n;
      data_sel = !space_select_pin;
    end else begin
      code_sel = !memory_chip_enable_n && !space_select_pin;
      data_sel = !memory_chip_enable_n && space_select_pin;
    end
  end
endmodule : ext_mem_model

// >>> verif/test_fpu_config_register_upper.sv
// Self-checking testbench for the configuration register block.
`timescale 1ns/10ps
`include "fpu_cfg_params.svh"
module test_fpu_config_register_upper;
  import fpu_cfg_pkg::*;
  localparam logic REV = 1'b0; // Arbitrary.
  logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, coproc_mode, local_output_enable;
  logic cas_core, we_core, coproc_ready_out_core, address_latch_out_core, setmask_boundary;
  logic lad_move_active, lad_move_bit1, lad_drive, mem_access, mem_is_data;
  logic exception_detected_flag, irq, column_strobe_out, column_strobe_oe;
  logic write_strobe_out, write_strobe_oe, coproc_ready_out;
  logic cycle_boundary_out, address_latch_out, local_addr_data_bus_oe;
  logic memory_chip_enable_n, space_select_pin, code_sel, data_sel, ms;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [5:0] mul_exception, mul_mask;
  logic [4:0] alu_exception, alu_mask;
  logic [6:0] low_cfg;
  logic [31:0] lad_core_data, local_addr_data_bus_o;
  word_t s_axi_wdata, s_axi_rdata, v;
  axi_resp_t s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q[$];
  logic [15:0] lfsr;
  int n_errors, tests_run;

  fpu_config_register_upper #(.REVISION_VALUE(REV)) uut (.*);
  ext_mem_model u_mem (.memory_chip_enable_n, .space_select_pin,
                       .split_mode(ms), .code_sel, .data_sel);

  always #50 mclk = ~mclk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // --------------------------------------------------------------------
  // Register bus master
  // --------------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input word_t d);
    logic ta, tw, tb;
    tb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    @(posedge mclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input word_t d,
                          input axi_resp_t r);
    logic ta, tr;
    tr = 1'b0;
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    @(posedge mclk);
  endtask : axi_read

  always @(posedge mclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
  end

  always @(posedge mclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      check(s_axi_bresp, RESP_OKAY);
    end
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    {mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, coproc_mode, local_output_enable} = '0;
    {cas_core, we_core, coproc_ready_out_core, address_latch_out_core, setmask_boundary} = '0;
    {lad_move_active, lad_move_bit1, lad_drive, mem_access} = '0;
    {mem_is_data, s_axi_awaddr, s_axi_araddr, mul_exception} = '0;
    {alu_exception, lad_core_data, s_axi_wdata, ms} = '0;
    s_axi_wstrb = 4'hf;
    rst = 1'b1;
    lfsr = 16'ha832;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    axi_read(8'h00, 32'hffe00020 | {REV, 10'h000}, RESP_OKAY);
    axi_read(8'h04, 32'h0, RESP_OKAY);
    axi_read(8'h08, 32'h0, RESP_OKAY);
    axi_read(8'h0c, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      v = (i == 0) ? 32'hffffff7f : {lfsr, lfsr} & 32'hffffff7f;
      axi_write(8'h00, v);
      axi_read(8'h00, (v & `CFG_WR_MASK) | {REV, 10'h000}, RESP_OKAY);
      check(low_cfg, v[6:0]);
    end
    axi_write(8'h00, {6'h2a, 5'h0d, 21'h000020});
    check({mul_mask, alu_mask}, {6'h2a, 5'h0d});
    mul_exception <= 6'h3f;
    alu_exception <= 5'h1f;
    @(posedge mclk);
    {mul_exception, alu_exception} <= '0;
    axi_read(8'h04, {20'h0, 1'b1, 5'h0d, 6'h2a}, RESP_OKAY);
    check(irq, 1'b0);
    axi_write(8'h08, 32'h800);
    check(irq, 1'b1);
    axi_write(8'h04, 32'hfff);
    check(irq, 1'b0);
    mul_exception <= 6'h15;
    @(posedge mclk);
    mul_exception <= '0;
    axi_read(8'h04, 32'h0, RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      axi_write(8'h00, 32'hffe00020 | {m[1:0], 8'h00});
      ms <= m[0];
      for (int i = 0; i < 16; i++) begin
        lfsr = lfsr_next(lfsr);
        {mem_is_data, mem_access, lad_drive, lad_move_bit1} <= lfsr[11:8];
        {lad_move_active, setmask_boundary, address_latch_out_core} <= lfsr[7:5];
        {coproc_ready_out_core, we_core, cas_core} <= lfsr[4:2];
        {local_output_enable, coproc_mode} <= lfsr[1:0];
        lad_core_data <= {lfsr, lfsr};
        @(posedge mclk);
        @(negedge mclk);
        v[0] = m[1] && !coproc_mode && local_output_enable;
        v[1] = (m[1] && !coproc_mode) ? !(lad_move_active && lad_move_bit1)
                                      : setmask_boundary;
        v[2] = m[0] ? !(mem_access && !mem_is_data) : !mem_access;
        v[3] = m[0] ? !(mem_access && mem_is_data) : mem_is_data;
        v[4] = mem_access && !mem_is_data;
        v[5] = mem_access && mem_is_data;
        check({column_strobe_oe, write_strobe_oe, column_strobe_out,
               write_strobe_out, coproc_ready_out, address_latch_out,
               cycle_boundary_out, local_addr_data_bus_oe,
               memory_chip_enable_n, space_select_pin, code_sel, data_sel},
              {!v[0], !v[0], cas_core, we_core, coproc_ready_out_core, address_latch_out_core,
               v[1], lad_drive && !v[0], v[2], v[3],
               v[4], v[5]});
        check(local_addr_data_bus_o, lad_core_data);
        @(posedge mclk);
      end
    end
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
endmodule : test_fpu_config_register_upper
